// ### hdl/rxpf_pkg.sv
// package: register map, field layout and reset values of the receive packet-format block
package rxpf_pkg;
  // register indices (printed offsets not all multiples of four: index, byte address = 4 x index)
  localparam logic [7:0] RXPF_IDX_HDR_CTRL2 = 8'h33;
  localparam logic [7:0] RXPF_IDX_PREA_LOW = 8'h34;
  localparam logic [7:0] RXPF_IDX_PREA_DET = 8'h35;
  localparam logic [7:0] RXPF_IDX_SYNC3 = 8'h36;
  localparam logic [7:0] RXPF_IDX_SYNC2 = 8'h37;
  localparam logic [7:0] RXPF_IDX_SYNC1 = 8'h38;
  localparam logic [7:0] RXPF_IDX_SYNC0 = 8'h39;
  localparam logic [7:0] RXPF_IDX_PAY_LEN = 8'h3e;
  localparam logic [7:0] RXPF_IDX_CHECK3 = 8'h3f;
  localparam logic [7:0] RXPF_IDX_HDR_EN3 = 8'h43;
  localparam logic [7:0] RXPF_IDX_RX_HDR3 = 8'h47;
  localparam logic [7:0] RXPF_IDX_RX_LEN = 8'h4b;
  localparam logic [7:0] RXPF_IDX_CTRL = 8'h50;
  localparam logic [7:0] RXPF_IDX_STATUS = 8'h51;
  // field positions in header_control_two
  localparam int RXPF_HDLEN_LSB = 4;
  localparam int RXPF_FIXLEN_BIT = 3;
  localparam int RXPF_SYNCLEN_LSB = 1;
  localparam int RXPF_PREA_MSB_BIT = 0;
  // reset values
  localparam logic [6:0] RXPF_RST_HDR_CTRL2 = 7'h00;
  localparam logic [7:0] RXPF_RST_PREA_LOW = 8'h08;
  localparam logic [7:0] RXPF_RST_PREA_DET = 8'h00;
  localparam logic [7:0] RXPF_RST_SYNC3 = 8'h2d;
  localparam logic [7:0] RXPF_RST_SYNC2 = 8'hd4;
  localparam logic [7:0] RXPF_RST_SYNC1 = 8'h00;
  localparam logic [7:0] RXPF_RST_SYNC0 = 8'h00;
  localparam logic [7:0] RXPF_RST_PAY_LEN = 8'h00;
  localparam logic [31:0] RXPF_RST_CHECK = 32'h00000000;
  localparam logic [31:0] RXPF_RST_HDR_EN = 32'h00000000;
  localparam logic [7:0] RXPF_RST_RX_LEN = 8'hff;
  localparam logic [31:0] RXPF_BUS_OKAY = 32'h00000000;
  localparam logic [1:0] RXPF_RESP_OKAY = 2'b00;
  localparam logic [1:0] RXPF_RESP_SLVERR = 2'b10;
  localparam logic [2:0] RXPF_DB_DB = 3'd4;
endpackage

// ### hdl/rxpf_top.sv
// receive packet-format configuration, frame parser and header matcher with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R1] header length selects bytes 3, 3-2, 3-1, 3-0
// [R2] header bytes arrive highest numbered first
// [R3] fixed flag set: no length byte expected
// [R4] sync length selects one to four bytes
// [R5] transmitter sends sync bytes from byte 3
// [R6] nine-bit preamble length in nibbles, split
// [R7] preamble length resets to eight nibbles
// [R8] all nine bits set is the maximum
// [R9] preamble length zero acts as one
// [R10] detect threshold nibbles in bits 7:3
// [R11] rssi offset adds 4 dB per step
// [R12] sync byte 3 resets to 0x2d
// [R13] sync byte 2 0xd4, byte 0 zero
// [R14] payload length in bytes, resets zero
// [R15] payload length up to 255 bytes
// [R16] zero payload length means no data
// [R17] fixed mode uses programmed payload length
// [R18] check bytes compared with received header
// [R19] packet handling only when enabled
// [R20] header compare masked per enable bit
// [R21] order: sync, header, length, payload
// [R22] reserved bit 7 reads zero
module rxpf_top import rxpf_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic preamble_found,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  output logic [7:0] payload_byte,
  output logic payload_valid,
  output logic [8:0] preamble_nibbles,
  output logic [4:0] detect_threshold,
  output logic [4:0] rssi_offset_db,
  output logic packet_done,
  output logic header_ok
);
  // ***********************
  // state
  // ***********************
  typedef enum logic [4:0] {
    RXPF_IDLE = 5'b00001,
    RXPF_SYNC = 5'b00010,
    RXPF_HDR = 5'b00100,
    RXPF_LEN = 5'b01000,
    RXPF_PAY = 5'b10000
  } rxpf_state_t;

  rxpf_state_t state;
  logic [6:0] hdr_ctrl;
  logic [7:0] prea_low, prea_det, pay_len, rx_len, count, rd_word, aw_idx, wbyte;
  logic [7:0] sync_pat [4];
  logic [31:0] check_hdr, hdr_en, rx_hdr;
  logic enable_rx, mismatch, rd_hit, wr_hit, aw_have, w_have, fix_len, w_done;
  logic [1:0] idx, sy_len, w_lane, r_lane;
  logic [2:0] hd_len;

  // fields decoded from the header_control_two register (hdr_ctrl)
  assign hd_len = hdr_ctrl[RXPF_HDLEN_LSB +: 3];
  assign sy_len = hdr_ctrl[RXPF_SYNCLEN_LSB +: 2];
  assign fix_len = hdr_ctrl[RXPF_FIXLEN_BIT];
  // byte lane in 2-bit arithmetic; all three banks start on lane 3
  assign w_lane = 2'd3 - (aw_idx[1:0] - RXPF_IDX_CHECK3[1:0]);
  assign r_lane = 2'd3 - (s_axi_araddr[3:2] - RXPF_IDX_CHECK3[1:0]);

  // ***********************
  // axi4-lite write
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      aw_idx <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have <= 1'b1;
      aw_idx <= s_axi_awaddr[9:2];
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have <= 1'b0;
      wbyte <= 8'h00;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have <= s_axi_wstrb[0];
      wbyte <= s_axi_wdata[7:0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_done <= 1'b0;
    end else begin
      w_done <= aw_have && !s_axi_awready && !s_axi_wready && !s_axi_bvalid && !w_done;
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    unique case (aw_idx)
      RXPF_IDX_HDR_CTRL2, RXPF_IDX_PREA_LOW, RXPF_IDX_PREA_DET, RXPF_IDX_SYNC3,
      RXPF_IDX_SYNC2, RXPF_IDX_SYNC1, RXPF_IDX_SYNC0, RXPF_IDX_PAY_LEN,
      RXPF_IDX_CTRL: wr_hit = 1'b1;
      default: wr_hit = (aw_idx >= RXPF_IDX_CHECK3) && (aw_idx < RXPF_IDX_RX_HDR3);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RXPF_RESP_OKAY;
    end else if (w_done) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RXPF_RESP_OKAY : RXPF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ***********************
  // configuration registers
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hdr_ctrl <= RXPF_RST_HDR_CTRL2;
      prea_low <= RXPF_RST_PREA_LOW; // R7
      prea_det <= RXPF_RST_PREA_DET;
      sync_pat[3] <= RXPF_RST_SYNC3; // R12
      sync_pat[2] <= RXPF_RST_SYNC2; // R13
      sync_pat[1] <= RXPF_RST_SYNC1;
      sync_pat[0] <= RXPF_RST_SYNC0; // R13
      pay_len <= RXPF_RST_PAY_LEN; // R14
      check_hdr <= RXPF_RST_CHECK;
      hdr_en <= RXPF_RST_HDR_EN;
      enable_rx <= 1'b0;
    end else if (w_done && w_have) begin
      unique case (aw_idx)
        RXPF_IDX_HDR_CTRL2: hdr_ctrl <= wbyte[6:0]; // R22
        RXPF_IDX_PREA_LOW: prea_low <= wbyte;
        RXPF_IDX_PREA_DET: prea_det <= wbyte;
        RXPF_IDX_SYNC3: sync_pat[3] <= wbyte;
        RXPF_IDX_SYNC2: sync_pat[2] <= wbyte;
        RXPF_IDX_SYNC1: sync_pat[1] <= wbyte;
        RXPF_IDX_SYNC0: sync_pat[0] <= wbyte;
        RXPF_IDX_PAY_LEN: pay_len <= wbyte; // R15
        RXPF_IDX_CTRL: enable_rx <= wbyte[0];
        default: begin
          if (aw_idx >= RXPF_IDX_CHECK3 && aw_idx < RXPF_IDX_HDR_EN3) begin
            check_hdr[8 * w_lane +: 8] <= wbyte;
          end else if (aw_idx >= RXPF_IDX_HDR_EN3 && aw_idx < RXPF_IDX_RX_HDR3) begin
            hdr_en[8 * w_lane +: 8] <= wbyte;
          end
        end
      endcase
    end
  end

  // ***********************
  // derived settings
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preamble_nibbles <= {1'b0, RXPF_RST_PREA_LOW};
      detect_threshold <= 5'h00;
      rssi_offset_db <= 5'h00;
    end else begin
      // zero acts as one; all ones is the maximum
      preamble_nibbles <= ({hdr_ctrl[RXPF_PREA_MSB_BIT], prea_low} == 9'h000) ? 9'h001 :
                          {hdr_ctrl[RXPF_PREA_MSB_BIT], prea_low}; // R6 R8 R9
      detect_threshold <= prea_det[7:3]; // R10
      rssi_offset_db <= {prea_det[2:0], 2'b00}; // R11
    end
  end

  // ***********************
  // read channel
  // ***********************
  always_comb begin
    rd_word = 8'h00;
    rd_hit = 1'b1;
    unique case (s_axi_araddr[9:2])
      RXPF_IDX_HDR_CTRL2: rd_word = {1'b0, hdr_ctrl}; // R22
      RXPF_IDX_PREA_LOW: rd_word = prea_low;
      RXPF_IDX_PREA_DET: rd_word = prea_det;
      RXPF_IDX_SYNC3: rd_word = sync_pat[3];
      RXPF_IDX_SYNC2: rd_word = sync_pat[2];
      RXPF_IDX_SYNC1: rd_word = sync_pat[1];
      RXPF_IDX_SYNC0: rd_word = sync_pat[0];
      RXPF_IDX_PAY_LEN: rd_word = pay_len;
      RXPF_IDX_RX_LEN: rd_word = rx_len;
      RXPF_IDX_CTRL: rd_word = {7'h00, enable_rx};
      RXPF_IDX_STATUS: rd_word = {3'h0, state};
      default: begin
        if (s_axi_araddr[9:2] >= RXPF_IDX_CHECK3 && s_axi_araddr[9:2] < RXPF_IDX_HDR_EN3) begin
          rd_word = check_hdr[8 * r_lane +: 8];
        end else if (s_axi_araddr[9:2] >= RXPF_IDX_HDR_EN3 &&
                     s_axi_araddr[9:2] < RXPF_IDX_RX_HDR3) begin
          rd_word = hdr_en[8 * r_lane +: 8];
        end else if (s_axi_araddr[9:2] >= RXPF_IDX_RX_HDR3 &&
                     s_axi_araddr[9:2] < RXPF_IDX_RX_LEN) begin
          rd_word = rx_hdr[8 * r_lane +: 8];
        end else begin
          rd_hit = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RXPF_BUS_OKAY;
      s_axi_rresp <= RXPF_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_word};
      s_axi_rresp <= rd_hit ? RXPF_RESP_OKAY : RXPF_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***********************
  // frame parser
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= RXPF_IDLE;
      idx <= 2'd3;
      count <= 8'h00;
      mismatch <= 1'b0;
      rx_hdr <= 32'h00000000;
      rx_len <= RXPF_RST_RX_LEN;
      payload_byte <= 8'h00;
      payload_valid <= 1'b0;
      packet_done <= 1'b0;
      header_ok <= 1'b0;
    end else begin
      payload_valid <= 1'b0;
      packet_done <= 1'b0;
      unique case (state)
        RXPF_IDLE: begin
          if (preamble_found) begin // R21
            state <= RXPF_SYNC;
            idx <= 2'd3; // R5
            header_ok <= 1'b0;
          end
        end
        RXPF_SYNC: begin
          if (rx_byte_valid) begin
            if (rx_byte != sync_pat[idx]) begin // R4
              state <= RXPF_IDLE;
            end else if (idx == 2'd3 - sy_len) begin
              idx <= 2'd3; // R2
              mismatch <= 1'b0;
              count <= 8'h00;
              if (!enable_rx) begin // R19
                state <= RXPF_PAY;
              end else if (hd_len != 3'd0) begin // R1
                state <= RXPF_HDR;
              end else if (!fix_len) begin // R3
                state <= RXPF_LEN;
              end else begin
                state <= RXPF_PAY;
                rx_len <= pay_len; // R17
                header_ok <= 1'b1;
                if (pay_len == 8'h00) begin // R16
                  state <= RXPF_IDLE;
                  packet_done <= 1'b1;
                end
              end
            end else begin
              idx <= idx - 2'd1;
            end
          end
        end
        RXPF_HDR: begin
          if (rx_byte_valid) begin
            rx_hdr[8 * idx +: 8] <= rx_byte; // R2
            // masked per bit against check bytes
            if (((rx_byte ^ check_hdr[8 * idx +: 8]) & hdr_en[8 * idx +: 8]) != 8'h00) begin
              mismatch <= 1'b1; // R18 R20
            end
            idx <= idx - 2'd1;
            if ({1'b0, idx} == 3'd4 - ((hd_len > 3'd4) ? RXPF_DB_DB : hd_len)) begin // R1
              if (!fix_len) begin
                state <= RXPF_LEN; // R3
              end else begin
                state <= RXPF_PAY;
                rx_len <= pay_len; // R17
                header_ok <= !mismatch &&
                  (((rx_byte ^ check_hdr[8 * idx +: 8]) & hdr_en[8 * idx +: 8]) == 8'h00);
                if (pay_len == 8'h00) begin // R16
                  state <= RXPF_IDLE;
                  packet_done <= 1'b1;
                end
              end
            end
          end
        end
        RXPF_LEN: begin
          if (rx_byte_valid) begin
            rx_len <= rx_byte; // R21
            header_ok <= !mismatch;
            state <= (rx_byte == 8'h00) ? RXPF_IDLE : RXPF_PAY; // R16
            packet_done <= (rx_byte == 8'h00);
          end
        end
        RXPF_PAY: begin
          if (!enable_rx) begin // R19
            if (rx_byte_valid) begin
              payload_byte <= rx_byte;
              payload_valid <= 1'b1;
            end
            if (preamble_found) begin
              state <= RXPF_SYNC;
              idx <= 2'd3;
            end
          end else if (rx_byte_valid) begin
            payload_byte <= rx_byte;
            payload_valid <= 1'b1;
            count <= count + 8'h01;
            if (count + 8'h01 == rx_len) begin // R15
              state <= RXPF_IDLE;
              packet_done <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### tb/rxpf_checker_props.sv
// checker: bus handshake and frame output properties
`timescale 1ns/1ps
`default_nettype none
module rxpf_checker_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid,
  input wire logic [7:0] payload_byte,
  input wire logic payload_valid,
  input wire logic [4:0] rssi_offset_db,
  input wire logic packet_done
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_wr_answer: assert property (wr_taken |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
  chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_pay_source: assert property (payload_valid |->
    $past(rx_byte_valid) && payload_byte == $past(rx_byte))
    else $error("payload not from last byte");
  chk_done_pulse: assert property (packet_done |=> !packet_done)
    else $error("done longer than one cycle");
  chk_done_on_byte: assert property (packet_done |-> $past(rx_byte_valid))
    else $error("done without a received byte");
  chk_rssi_step: assert property (rssi_offset_db[1:0] == 2'b00)
    else $error("rssi offset not 4 dB steps");
endmodule
`default_nettype wire

// ### tb/rxpf_tx_model.sv
// transmitter model: preamble strobe, then queued bytes in order
`timescale 1ns/1ps
`default_nettype none
module rxpf_tx_model (
  input wire logic aclk,
  input wire logic [1:0] gap,
  output logic preamble_found,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid
);
  logic [8:0] q[$];
  logic [8:0] item;
  logic [1:0] cnt;
  initial begin
    preamble_found = 1'b0;
    rx_byte = 8'h00;
    rx_byte_valid = 1'b0;
    cnt = 2'd0;
  end
  // queue order is air order; idle data line toggles
  always @(posedge aclk) begin
    preamble_found <= 1'b0;
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    if (cnt != 2'd0) begin
      cnt <= cnt - 2'd1;
    end else if (q.size() != 0) begin
      item = q.pop_front();
      cnt <= gap;
      if (item[8]) begin
        preamble_found <= 1'b1;
      end else begin
        rx_byte <= item[7:0];
        rx_byte_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/rxpf_top_test.sv
// testbench: register map, frame parsing and header matching
`timescale 1ns/1ps
`default_nettype none
module rxpf_top_test import rxpf_pkg::*; ;
  localparam logic [7:0] RIDX [8] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3e, 8'h4b};
  localparam logic [7:0] RVAL [8] = '{8'h00, 8'h08, 8'h00, 8'h2d, 8'hd4, 8'h00, 8'h00, 8'hff};
  localparam logic [7:0] LENS [4] = '{8'd3, 8'd255, 8'd0, 8'd1};
  localparam logic [31:0] SYNC = 32'h2dd45a00;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, raw, due;
  logic awready, wready, bvalid, arready, rvalid, pay_v, done, hok, pf, rxv;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0] bresp, rresp, gap;
  logic [7:0] rxb, pay_b, chk_a[4], en_a[4];
  logic [8:0] pre_n;
  logic [4:0] det_th, rssi;
  logic [15:0] seed;
  logic [33:0] exp_r[$];
  logic [7:0] exp_p[$];
  logic exp_ok[$];
  int error_cnt, comparisons;
  rxpf_top rxpf_top_inst (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .preamble_found(pf), .rx_byte(rxb), .rx_byte_valid(rxv), .payload_byte(pay_b),
    .payload_valid(pay_v), .preamble_nibbles(pre_n), .detect_threshold(det_th),
    .rssi_offset_db(rssi), .packet_done(done), .header_ok(hok));
  rxpf_tx_model rxpf_tx_model_inst (.aclk, .gap, .preamble_found(pf), .rx_byte(rxb),
    .rx_byte_valid(rxv));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ready is registered, so its level at the falling edge holds at the next rise
  task automatic wt(ref logic s);
    logic a;
    do begin
      @(negedge aclk);
      a = s;
      @(posedge aclk);
    end while (!a);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] r = RXPF_RESP_OKAY);
    logic a, w;
    exp_r.push_back({r, 32'h0});
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    while (!(a && w)) begin
      @(negedge aclk);
      a = a || awready;
      w = w || wready;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    wt(bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] r = RXPF_RESP_OKAY);
    exp_r.push_back({r, 24'h0, d});
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    wt(arready);
    arvalid <= 1'b0;
    wt(rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic push(input logic [8:0] x);
    rxpf_tx_model_inst.q.push_back(x);
  endtask
  task automatic frame(input int sl, input int hl, input logic fx, input logic [7:0] len,
    input logic miss);
    logic [7:0] v, h3;
    wr(8'h33, {1'b0, 3'(hl), fx, 2'(sl), 1'b0});
    wr(8'h3e, fx ? len : 8'h07);
    for (int k = 0; k < 4; k++) begin
      rnd(chk_a[k]);
      rnd(en_a[k]);
      en_a[0][7] = 1'b1;
      wr(8'h3f + 8'(k), chk_a[k]);
      wr(8'h43 + 8'(k), en_a[k]);
    end
    gap <= len == 8'd255 ? 2'd0 : seed[1:0];
    if (miss) begin
      push(9'h100);
      push({1'b0, ~SYNC[31:24]});
      push(9'h0a5);
    end
    push(9'h100);
    for (int k = 0; k <= sl; k++) push({1'b0, SYNC[31 - 8 * k -: 8]});
    for (int k = 0; k < hl; k++) begin
      rnd(v);
      v = chk_a[k] ^ (v & ~en_a[k]);
      if (k == 0) v[7] = v[7] ^ miss;
      if (k == 0) h3 = v;
      push({1'b0, v});
    end
    if (!fx) push({1'b0, len});
    for (int k = 0; k < len; k++) begin
      rnd(v);
      exp_p.push_back(v);
      push({1'b0, v});
    end
    if (!raw) exp_ok.push_back(!miss);
    for (int k = 0; k < 4000 && exp_p.size() + exp_ok.size() != 0; k++) @(posedge aclk);
    check(34'(exp_p.size() + exp_ok.size()), 34'd0);
    if (hl > 0) rd(8'h47, h3);
  endtask
  always @(negedge aclk) begin
    if (bvalid && bready) check({bresp, 32'h0}, exp_r.pop_front());
    if (rvalid && rready) check({rresp, rdata}, exp_r.pop_front());
    if (pay_v) check(34'(pay_b), 34'(exp_p.pop_front()));
    if (due) check(34'(hok), 34'(exp_ok.pop_front()));
    due = done && !raw;
  end
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    test_done;
  end
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, raw, due} = '0;
    {awaddr, wdata, araddr} = '0;
    gap = 2'd0;
    seed = 16'd20738;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check(34'(pre_n), 34'd8);
    for (int k = 0; k < 8; k++) rd(RIDX[k], RVAL[k]);
    rd(8'h10, 8'h00, RXPF_RESP_SLVERR);
    wr(8'h10, 8'h55, RXPF_RESP_SLVERR);
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h7f);
    wr(8'h34, 8'hff);
    wr(8'h35, 8'hb5);
    repeat (2) @(posedge aclk);
    check(34'({pre_n, det_th, rssi}), 34'({9'h1ff, 5'h16, 5'd20}));
    wr(8'h33, 8'h00);
    wr(8'h34, 8'h00);
    repeat (2) @(posedge aclk);
    check(34'(pre_n), 34'd1);
    wr(8'h38, 8'h5a);
    wr(8'h50, 8'h01);
    for (int i = 0; i < 4; i++) frame(i, i == 0 ? 0 : i + 1, i[0], LENS[i], i[0]);
    raw = 1'b1;
    wr(8'h50, 8'h00);
    frame(0, 0, 1'b1, 8'd3, 1'b0);
    test_done;
  end
endmodule
bind rxpf_top rxpf_checker_props rxpf_checker_props_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .rx_byte, .rx_byte_valid, .payload_byte,
  .payload_valid, .rssi_offset_db, .packet_done);
`default_nettype wire
